// >>> rtl/analog_monitor_regs.svh
//----------------------------------------------------------------------
// Purpose: Register map, reset values and scale constants of the monitor
// Assumes: 32-bit Wishbone data, byte addresses on an 8-bit address
// Notes:   Voltages inside the block are in mV, sums in 0.01 mV
//----------------------------------------------------------------------
`ifndef ANALOG_MONITOR_REGS_SVH
`define ANALOG_MONITOR_REGS_SVH

//----------------------------------------------------------------------
// Register offsets
//----------------------------------------------------------------------
`define AM_SEL1_OFS 8'h00
`define AM_SEL2_OFS 8'h04
`define AM_OFF1_OFS 8'h08
`define AM_OFF2_OFS 8'h0c
`define AM_MUL1_OFS 8'h10
`define AM_MUL2_OFS 8'h14
`define AM_OUT1_OFS 8'h18
`define AM_OUT2_OFS 8'h1c
`define AM_STAT_OFS 8'h20

//----------------------------------------------------------------------
// Status field positions
//----------------------------------------------------------------------
`define AM_STAT_DD_BIT 0
`define AM_STAT_POSCTL_BIT 1
`define AM_STAT_GAIN2_BIT 2

//----------------------------------------------------------------------
// Reset values and setting limits
//----------------------------------------------------------------------
`define AM_SEL1_RST 8'h02
`define AM_SEL2_RST 8'h00
`define AM_OFF_RST 16'sh0000
`define AM_MUL_RST 16'sh0064
`define AM_SET_MAX 16'sh2710
`define AM_SET_MIN 16'shd8f0

//----------------------------------------------------------------------
// Scale factors, signal levels and converter code limits
//----------------------------------------------------------------------
`define AM_DD_SPEED_GAIN 40'sh0a
`define AM_MV_PER_POS_ERR 40'sh32
`define AM_MV_PER_LOAD_ERR 40'sh0a
`define AM_MV_FLAG_HI 40'sh1388
`define AM_MV_GAIN1 40'sh3e8
`define AM_MV_GAIN2 40'sh7d0
`define AM_OFS_TO_CMV 64'sh2710
`define AM_DAC_MUL 64'sh863
`define AM_DAC_SHIFT 16
`define AM_SAT_HI 64'sh7fff
`define AM_SAT_LO -64'sh8000
`define AM_DAC_MAX 16'sh7fff
`define AM_DAC_MIN 16'sh8000

`endif

// >>> rtl/analog_monitor_pkg.sv
//----------------------------------------------------------------------
// Purpose: Types shared by the monitor modules
// Assumes: Signed inputs in native units of the drive
// Notes:   Selection codes follow the two low hex digits of the setting
//----------------------------------------------------------------------
package analog_monitor_pkg;

   typedef logic signed [15:0] dac_t;
   typedef logic signed [39:0] mv_t;

   typedef enum logic [7:0] {
      SEL_MOTOR_SPEED = 8'h00,
      SEL_SPEED_REF = 8'h01,
      SEL_TORQUE_REF = 8'h02,
      SEL_POS_ERR = 8'h03,
      SEL_POS_AMP_ERR = 8'h04,
      SEL_POS_REF_SPEED = 8'h05,
      SEL_RESERVED = 8'h06,
      SEL_LOAD_POS_ERR = 8'h07,
      SEL_POS_DONE = 8'h08,
      SEL_SPEED_FF = 8'h09,
      SEL_TORQUE_FF = 8'h0a,
      SEL_ACTIVE_GAIN = 8'h0b,
      SEL_REF_DONE = 8'h0c,
      SEL_EXT_ENC_SPEED = 8'h0d
   } monitor_sel_e;

   typedef struct packed {
      logic signed [15:0] motor_speed;
      logic signed [15:0] speed_ref;
      logic signed [15:0] torque_ref;
      logic signed [31:0] pos_err;
      logic signed [31:0] pos_amp_err;
      logic signed [15:0] ref_pulse_speed;
      logic [7:0] pulse_mult;
      logic signed [31:0] load_pos_err;
      logic pos_done;
      logic signed [15:0] speed_ff;
      logic signed [15:0] torque_ff;
      logic gain2_active;
      logic ref_done;
      logic signed [15:0] ext_enc_speed;
      logic pos_control;
      logic direct_drive;
   } monitor_src_s;

endpackage

// >>> rtl/monitor_chan_if.sv
//----------------------------------------------------------------------
// Purpose: Selected channel voltage passed from selector to scaler
// Assumes: One producer, one consumer
// Notes:   mv is in mV; zero forces the converter code to 0
//----------------------------------------------------------------------
`timescale 1ns/1ps
interface monitor_chan_if;
   logic signed [39:0] mv;
   logic zero;
   modport src (output mv, output zero);
   modport dst (input mv, input zero);
endinterface

// >>> rtl/monitor_source_mux.sv
//----------------------------------------------------------------------
// Purpose: Picks one internal quantity and turns it into mV
// Assumes: Speeds in rpm, torques in 0.1 % rated, errors in counts
// Notes:   One register stage
//----------------------------------------------------------------------
`timescale 1ns/1ps
`include "analog_monitor_regs.svh"
module monitor_source_mux (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Sync reset
   input wire logic [7:0] sel_i, // Selection code
   input analog_monitor_pkg::monitor_src_s src_i, // Internal quantities
   monitor_chan_if.src ch // Selected voltage
);
   import analog_monitor_pkg::*;

   logic signed [39:0] val_nxt;
   logic signed [39:0] spd;
   logic is_spd;
   logic zero_nxt;

   always_comb
   begin
      val_nxt = '0;
      spd = '0;
      is_spd = 1'b0;
      zero_nxt = 1'b0;
      case (sel_i)
         SEL_MOTOR_SPEED:
         begin
            spd = 40'(src_i.motor_speed);
            is_spd = 1'b1;
         end
         SEL_SPEED_REF:
         begin
            spd = 40'(src_i.speed_ref);
            is_spd = 1'b1;
         end
         SEL_POS_REF_SPEED:
         begin
            spd = 40'(src_i.ref_pulse_speed * $signed({1'b0, src_i.pulse_mult}));
            is_spd = 1'b1;
         end
         SEL_SPEED_FF:
         begin
            spd = 40'(src_i.speed_ff);
            is_spd = 1'b1;
         end
         SEL_TORQUE_REF: val_nxt = 40'(src_i.torque_ref);
         SEL_TORQUE_FF: val_nxt = 40'(src_i.torque_ff);
         SEL_POS_ERR:
         begin
            if (src_i.pos_control)
               val_nxt = 40'(40'(src_i.pos_err) * `AM_MV_PER_POS_ERR);
            else
               val_nxt = '0;
         end
         SEL_POS_AMP_ERR: val_nxt = 40'(40'(src_i.pos_amp_err) * `AM_MV_PER_POS_ERR);
         SEL_LOAD_POS_ERR: val_nxt = 40'(40'(src_i.load_pos_err) * `AM_MV_PER_LOAD_ERR);
         SEL_POS_DONE: val_nxt = src_i.pos_done ? `AM_MV_FLAG_HI : '0;
         SEL_ACTIVE_GAIN: val_nxt = src_i.gain2_active ? `AM_MV_GAIN2 : `AM_MV_GAIN1;
         SEL_REF_DONE: val_nxt = src_i.ref_done ? `AM_MV_FLAG_HI : '0;
         SEL_EXT_ENC_SPEED: val_nxt = 40'(src_i.ext_enc_speed);
         default: zero_nxt = 1'b1;
      endcase
      if (is_spd)
         val_nxt = src_i.direct_drive ? 40'(spd * `AM_DD_SPEED_GAIN) : spd;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ch.mv <= '0;
         ch.zero <= 1'b1;
      end
      else
      begin
         ch.mv <= val_nxt;
         ch.zero <= zero_nxt;
      end
   end
endmodule

// >>> rtl/monitor_output_scale.sv
//----------------------------------------------------------------------
// Purpose: Applies multiplier, offset and sign, then saturates to 16 bits
// Assumes: Multiplier in 0.01 steps, offset in 0.1 V steps
// Notes:   Code full scale is about 10 V; one register stage
//----------------------------------------------------------------------
`timescale 1ns/1ps
`include "analog_monitor_regs.svh"
module monitor_output_scale (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Sync reset
   monitor_chan_if.dst ch, // Selected voltage
   input analog_monitor_pkg::dac_t mul_i, // Multiplier
   input analog_monitor_pkg::dac_t off_i, // Offset
   output analog_monitor_pkg::dac_t dac_o // Converter code
);
   import analog_monitor_pkg::*;

   logic signed [63:0] sum;
   logic signed [63:0] scaled;
   dac_t dac_nxt;

   always_comb
   begin
      sum = 64'(ch.mv) * 64'(mul_i) + 64'(off_i) * `AM_OFS_TO_CMV;
      scaled = (-sum * `AM_DAC_MUL) >>> `AM_DAC_SHIFT;
      if (ch.zero)
         dac_nxt = '0;
      else if (scaled > `AM_SAT_HI)
         dac_nxt = `AM_DAC_MAX;
      else if (scaled < `AM_SAT_LO)
         dac_nxt = `AM_DAC_MIN;
      else
         dac_nxt = scaled[15:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dac_o <= '0;
      else
         dac_o <= dac_nxt;
   end
endmodule

// >>> rtl/analog_monitor_scaler.sv
//----------------------------------------------------------------------
// Purpose: Two-channel analog monitor stage with Wishbone settings
// Assumes: All inputs synchronous to clk_i (200 MHz)
// Notes:   Converter codes appear two clocks after a selection change, one after a multiplier or offset change
//----------------------------------------------------------------------
//----------------------------------------------------------------------
//
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "analog_monitor_regs.svh"
module analog_monitor_scaler (
   input wire logic clk_i, // Clock, 200 MHz
   input wire logic rst_i, // Sync reset, active high
   input wire logic wb_cyc_i, // Wishbone cycle
   input wire logic wb_stb_i, // Wishbone strobe
   input wire logic wb_we_i, // Wishbone write enable
   input wire logic [7:0] wb_adr_i, // Wishbone byte address
   input wire logic [3:0] wb_sel_i, // Wishbone byte enables
   input wire logic [31:0] wb_dat_i, // Wishbone write data
   output logic [31:0] wb_dat_o, // Wishbone read data
   output logic wb_ack_o, // Wishbone acknowledge
   input wire logic signed [15:0] motor_speed_i, // Motor speed, rpm
   input wire logic signed [15:0] speed_ref_i, // Speed reference, rpm
   input wire logic signed [15:0] torque_ref_i, // Torque reference, 0.1 %
   input wire logic signed [31:0] pos_err_i, // Position error, ref units
   input wire logic signed [31:0] pos_amp_err_i, // Geared error, pulses
   input wire logic signed [15:0] ref_pulse_speed_i, // Pulse speed, rpm
   input wire logic [7:0] pulse_mult_i, // Input multiplication factor
   input wire logic signed [31:0] load_pos_err_i, // Motor-load error
   input wire logic pos_done_i, // Positioning completed
   input wire logic signed [15:0] speed_ff_i, // Speed feedforward, rpm
   input wire logic signed [15:0] torque_ff_i, // Torque feedforward, 0.1 %
   input wire logic gain2_active_i, // Second gain set active
   input wire logic ref_done_i, // Position reference completed
   input wire logic signed [15:0] ext_enc_speed_i, // External encoder, rpm
   input wire logic pos_control_i, // Drive in position control
   input wire logic direct_drive_i, // Direct-drive motor fitted
   output analog_monitor_pkg::dac_t monitor1_dac_o, // Channel one code
   output analog_monitor_pkg::dac_t monitor2_dac_o // Channel two code
);
   import analog_monitor_pkg::*;

   logic [7:0] sel_r [2];
   dac_t off_r [2];
   dac_t mul_r [2];
   dac_t dac [2];
   logic ack_r;
   logic [31:0] dat_r;
   logic [31:0] rd_nxt;
   logic req;
   logic wr_ev;
   monitor_src_s src;
   monitor_chan_if ch_if [2] ();

   //----------------------------------------------------------------------
   // Setting helpers
   //----------------------------------------------------------------------
   function automatic dac_t merge16(input dac_t old, input logic [31:0] d,
                                    input logic [3:0] be);
      merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction

   // Out-of-range settings are clamped, never refused
   function automatic dac_t clamp16(input dac_t v);
      if (v > `AM_SET_MAX)
         clamp16 = `AM_SET_MAX;
      else if (v < `AM_SET_MIN)
         clamp16 = `AM_SET_MIN;
      else
         clamp16 = v;
   endfunction

   //----------------------------------------------------------------------
   // Wishbone slave
   //----------------------------------------------------------------------
   // Ack falls for a cycle after each transfer so a held strobe
   // is taken at most every second clock; writes land on the ack edge
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_ev = req & wb_we_i & ack_r;
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_r <= 1'b0;
      else
         ack_r <= req & ~ack_r;
   end

   always_comb
   begin
      rd_nxt = '0;
      case (wb_adr_i)
         `AM_SEL1_OFS: rd_nxt = {24'h000000, sel_r[0]};
         `AM_SEL2_OFS: rd_nxt = {24'h000000, sel_r[1]};
         `AM_OFF1_OFS: rd_nxt = {16'h0000, off_r[0]};
         `AM_OFF2_OFS: rd_nxt = {16'h0000, off_r[1]};
         `AM_MUL1_OFS: rd_nxt = {16'h0000, mul_r[0]};
         `AM_MUL2_OFS: rd_nxt = {16'h0000, mul_r[1]};
         `AM_OUT1_OFS: rd_nxt = {16'h0000, dac[0]};
         `AM_OUT2_OFS: rd_nxt = {16'h0000, dac[1]};
         `AM_STAT_OFS:
         begin
            rd_nxt[`AM_STAT_DD_BIT] = direct_drive_i;
            rd_nxt[`AM_STAT_POSCTL_BIT] = pos_control_i;
            rd_nxt[`AM_STAT_GAIN2_BIT] = gain2_active_i;
         end
         default: rd_nxt = '0;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_r <= '0;
      else if (req & ~ack_r)
         dat_r <= rd_nxt;
   end

   //----------------------------------------------------------------------
   // Internal quantities
   //----------------------------------------------------------------------
   always_comb
   begin
      src.motor_speed = motor_speed_i;
      src.speed_ref = speed_ref_i;
      src.torque_ref = torque_ref_i;
      src.pos_err = pos_err_i;
      src.pos_amp_err = pos_amp_err_i;
      src.ref_pulse_speed = ref_pulse_speed_i;
      src.pulse_mult = pulse_mult_i;
      src.load_pos_err = load_pos_err_i;
      src.pos_done = pos_done_i;
      src.speed_ff = speed_ff_i;
      src.torque_ff = torque_ff_i;
      src.gain2_active = gain2_active_i;
      src.ref_done = ref_done_i;
      src.ext_enc_speed = ext_enc_speed_i;
      src.pos_control = pos_control_i;
      src.direct_drive = direct_drive_i;
   end

   //----------------------------------------------------------------------
   // Channels: settings, selector and scaler
   //----------------------------------------------------------------------
   for (genvar g = 0; g < 2; g++)
   begin : chan
      always_ff @(posedge clk_i)
      begin
         if (rst_i)
         begin
            sel_r[g] <= (g == 0) ? `AM_SEL1_RST : `AM_SEL2_RST;
            off_r[g] <= `AM_OFF_RST;
            mul_r[g] <= `AM_MUL_RST;
         end
         else if (wr_ev)
         begin
            if (wb_adr_i == (`AM_SEL1_OFS + 8'(4 * g)) && wb_sel_i[0])
               sel_r[g] <= wb_dat_i[7:0];
            if (wb_adr_i == (`AM_OFF1_OFS + 8'(4 * g)))
               off_r[g] <= clamp16(merge16(off_r[g], wb_dat_i, wb_sel_i));
            if (wb_adr_i == (`AM_MUL1_OFS + 8'(4 * g)))
               mul_r[g] <= clamp16(merge16(mul_r[g], wb_dat_i, wb_sel_i));
         end
      end

      monitor_source_mux u_mux (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .sel_i(sel_r[g]),
         .src_i(src),
         .ch(ch_if[g])
      );

      monitor_output_scale u_scale (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .ch(ch_if[g]),
         .mul_i(mul_r[g]),
         .off_i(off_r[g]),
         .dac_o(dac[g])
      );
   end

   assign monitor1_dac_o = dac[0];
   assign monitor2_dac_o = dac[1];

   //----------------------------------------------------------------------
   // Checks
   //----------------------------------------------------------------------
   // The release edge still sees reset-time channel values, so the
   // selection checks below avoid the channel one reset default code
   bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !ack_r |=> ack_r ##1 !ack_r)
      else $error("ack not a single cycle after request");

   sel_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_ev && wb_adr_i == `AM_SEL2_OFS && wb_sel_i[0]
      |=> sel_r[1] == $past(wb_dat_i[7:0]) && $stable(sel_r[0]))
      else $error("channel two select not written alone");

   reset_defaults_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> sel_r[0] == `AM_SEL1_RST && sel_r[1] == `AM_SEL2_RST
      && mul_r[0] == `AM_MUL_RST && off_r[0] == `AM_OFF_RST)
      else $error("settings not at factory values after reset");

   offset_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
      off_r[0] <= `AM_SET_MAX && off_r[0] >= `AM_SET_MIN
      && off_r[1] <= `AM_SET_MAX && off_r[1] >= `AM_SET_MIN)
      else $error("offset outside its range");

   dd_speed_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sel_r[1] == SEL_MOTOR_SPEED && direct_drive_i
      |=> ch_if[1].mv == 40'($past(motor_speed_i)) * `AM_DD_SPEED_GAIN)
      else $error("direct-drive speed not scaled by ten");

   pos_err_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sel_r[0] == SEL_POS_ERR && !pos_control_i |=> ch_if[0].mv == '0)
      else $error("position error not zero outside position control");

   done_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sel_r[0] == SEL_POS_DONE
      |=> ch_if[0].mv == ($past(pos_done_i) ? `AM_MV_FLAG_HI : 40'sh0))
      else $error("positioning flag voltage wrong");

   gain_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sel_r[1] == SEL_ACTIVE_GAIN
      |=> ch_if[1].mv == ($past(gain2_active_i) ? `AM_MV_GAIN2 : `AM_MV_GAIN1))
      else $error("active gain voltage wrong");

   out_sign_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ch_if[0].mv > 40'sh0 && mul_r[0] > 16'sh0 && off_r[0] == 16'sh0
      && !ch_if[0].zero |=> dac[0] <= 16'sh0)
      else $error("output not inverted");

   out_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ch_if[0].mv >= 40'sh0003e8 && mul_r[0] == `AM_SET_MAX && off_r[0] == 16'sh0
      && !ch_if[0].zero |=> dac[0] == `AM_DAC_MIN)
      else $error("output wrapped instead of saturating");

   reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (sel_r[1] == SEL_RESERVED || sel_r[1] > SEL_EXT_ENC_SPEED)[*3] |-> dac[1] == 16'sh0)
      else $error("reserved code does not give zero");

   pos_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sel_r[0] == SEL_POS_ERR && pos_control_i
      |=> ch_if[0].mv == 40'($past(pos_err_i)) * `AM_MV_PER_POS_ERR)
      else $error("position error scale wrong");

   mul_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
      mul_r[0] <= `AM_SET_MAX && mul_r[0] >= `AM_SET_MIN
      && mul_r[1] <= `AM_SET_MAX && mul_r[1] >= `AM_SET_MIN)
      else $error("multiplier outside its range");

   sel_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !wr_ev |=> $stable(sel_r[0]) && $stable(sel_r[1]))
      else $error("selection changed without a write");

   spd_ref_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sel_r[1] == SEL_SPEED_REF && !direct_drive_i
      |=> ch_if[1].mv == 40'($past(speed_ref_i)))
      else $error("speed reference scale wrong");

   amp_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sel_r[0] == SEL_POS_AMP_ERR
      |=> ch_if[0].mv == 40'($past(pos_amp_err_i)) * `AM_MV_PER_POS_ERR)
      else $error("geared position error scale wrong");

   ref_speed_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sel_r[0] == SEL_POS_REF_SPEED && !direct_drive_i
      |=> ch_if[0].mv == 40'($past(ref_pulse_speed_i)) * 40'($past(pulse_mult_i)))
      else $error("position reference speed not multiplied");

   load_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sel_r[1] == SEL_LOAD_POS_ERR
      |=> ch_if[1].mv == 40'($past(load_pos_err_i)) * `AM_MV_PER_LOAD_ERR)
      else $error("motor-load error scale wrong");

   ref_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sel_r[1] == SEL_REF_DONE
      |=> ch_if[1].mv == ($past(ref_done_i) ? `AM_MV_FLAG_HI : 40'sh0))
      else $error("reference done voltage wrong");

   enc_speed_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sel_r[0] == SEL_EXT_ENC_SPEED |=> ch_if[0].mv == 40'($past(ext_enc_speed_i)))
      else $error("external encoder speed scale wrong");

   torque_ff_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sel_r[0] == SEL_TORQUE_FF |=> ch_if[0].mv == 40'($past(torque_ff_i)))
      else $error("torque feedforward scale wrong");

   ch2_sign_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ch_if[1].mv > 40'sh0 && mul_r[1] > 16'sh0 && off_r[1] == 16'sh0
      && !ch_if[1].zero |=> dac[1] <= 16'sh0)
      else $error("channel two output not inverted");
endmodule

// >>> tb/monitor_recorder.sv
//----------------------------------------------------------------------
// Purpose: Recorder model that samples one converter code each clock
// Assumes: Signed 16-bit code, full scale near 10 V
// Notes:   Holds the last sample for the bench to inspect
//----------------------------------------------------------------------
`timescale 1ns/1ps
module monitor_recorder (
   input wire logic clk_i, // Clock
   input analog_monitor_pkg::dac_t code_i, // Converter code
   output analog_monitor_pkg::dac_t sample_o // Held sample
);
   import analog_monitor_pkg::*;
   always_ff @(posedge clk_i)
   begin
      sample_o <= code_i;
   end
endmodule

// >>> tb/analog_monitor_scaler_tb.sv
//----------------------------------------------------------------------
// Purpose: Self-checking bench for the two-channel monitor stage
// Assumes: Classic Wishbone master, settle of five clocks per change
// Notes:   Code 06 is never written; undefined codes stand in for it
//----------------------------------------------------------------------
`timescale 1ns/1ps
`include "analog_monitor_regs.svh"
module analog_monitor_scaler_tb;
   import analog_monitor_pkg::*;
   typedef struct {logic [7:0] sel; longint mv;} row_s;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rd, wb_dat_o;
   logic wb_ack_o;
   logic signed [15:0] spd = 16'sh03e8, sref = -16'sh01f4, tref = 16'sh03e8;
   logic signed [15:0] rps = 16'sh0064, sff = 16'sh07d0, tff = -16'sh012c;
   logic signed [15:0] eenc = 16'sh02bc;
   logic signed [31:0] perr = 32'sh14, paerr = -32'sh0a, lerr = 32'sh12c;
   logic [7:0] pmul = 8'h04;
   logic pdone = 1, g2 = 1, rdone = 1, pctl = 1, dd = 0;
   dac_t dac1, dac2, rec1, rec2;
   int err_total = 0, cmp_count = 0, cyc_n = 0;
   logic [7:0] radr[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h24};
   logic [31:0] rrst[8] = '{32'h2, 32'h0, 32'h0, 32'h0, 32'h64, 32'h64, 32'h6, 32'h0};
   // Selection code and expected mV at unity multiplier
   row_s rows[15] = '{'{8'h00, 1000}, '{8'h01, -500}, '{8'h02, 1000}, '{8'h03, 1000},
      '{8'h04, -500}, '{8'h05, 400}, '{8'h07, 3000}, '{8'h08, 5000}, '{8'h09, 2000},
      '{8'h0a, -300}, '{8'h0b, 2000}, '{8'h0c, 5000}, '{8'h0d, 700}, '{8'h0e, 0},
      '{8'hff, 0}};

   initial
   begin
      forever #2.5 clk_i = ~clk_i;
   end

   analog_monitor_scaler DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .motor_speed_i(spd), .speed_ref_i(sref), .torque_ref_i(tref),
      .pos_err_i(perr), .pos_amp_err_i(paerr), .ref_pulse_speed_i(rps),
      .pulse_mult_i(pmul), .load_pos_err_i(lerr), .pos_done_i(pdone),
      .speed_ff_i(sff), .torque_ff_i(tff), .gain2_active_i(g2),
      .ref_done_i(rdone), .ext_enc_speed_i(eenc), .pos_control_i(pctl),
      .direct_drive_i(dd), .monitor1_dac_o(dac1), .monitor2_dac_o(dac2));
   monitor_recorder rec_one (.clk_i(clk_i), .code_i(dac1), .sample_o(rec1));
   monitor_recorder rec_two (.clk_i(clk_i), .code_i(dac2), .sample_o(rec2));

   //-------------------------------------------------------------------
   // Helpers
   //-------------------------------------------------------------------
   function automatic dac_t exp_code(longint mv, longint mul, longint off);
      longint s;
      s = -(mv * mul + off * 10000) * 2147;
      s = s >>> 16;
      if (s > 32767)
         s = 32767;
      if (s < -32768)
         s = -32768;
      return dac_t'(s);
   endfunction

   task automatic chk(logic [31:0] got, logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'h3;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1)
         @(posedge clk_i);
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wt();
      repeat (5) @(posedge clk_i);
   endtask

   task automatic end_of_test();
      if (err_total == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clk_i)
   begin
      cyc_n++;
      if (cyc_n == 20000)
      begin
         err_total++;
         end_of_test();
      end
   end

   //-------------------------------------------------------------------
   // Main sequence
   //-------------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b1, 8'h24, 32'h1234);
      foreach (radr[i])
      begin
         wb(1'b0, radr[i], 32'h0);
         chk(rd, rrst[i]);
      end
      chk(rec1, exp_code(1000, 100, 0));
      chk(rec2, exp_code(1000, 100, 0));
      foreach (rows[i])
      begin
         wb(1'b1, `AM_SEL1_OFS, {24'h0, rows[i].sel});
         wb(1'b1, `AM_SEL2_OFS, {24'h0, rows[i].sel});
         wt();
         chk(rec1, exp_code(rows[i].mv, 100, 0));
         chk(rec2, exp_code(rows[i].mv, 100, 0));
      end
      wb(1'b1, `AM_SEL1_OFS, 32'h3);
      wb(1'b1, `AM_SEL2_OFS, 32'h0);
      @(posedge clk_i);
      pctl <= 1'b0;
      dd <= 1'b1;
      wt();
      chk(rec1, 32'h0);
      chk(rec2, exp_code(10000, 100, 0));
      @(posedge clk_i);
      pctl <= 1'b1;
      dd <= 1'b0;
      wb(1'b1, `AM_OFF2_OFS, 32'hffce);
      wb(1'b1, `AM_MUL2_OFS, 32'hfa);
      wt();
      chk(rec1, exp_code(1000, 100, 0));
      chk(rec2, exp_code(1000, 250, -50));
      wb(1'b1, `AM_MUL1_OFS, 32'h4e20);
      wt();
      chk(rec1, 32'hffff8000);
      wb(1'b0, `AM_MUL1_OFS, 32'h0);
      chk(rd, 32'h2710);
      wb(1'b1, `AM_OFF1_OFS, 32'h8000);
      wt();
      chk(rec1, 32'h7fff);
      wb(1'b0, `AM_OFF1_OFS, 32'h0);
      chk(rd, 32'hd8f0);
      wb(1'b1, `AM_MUL1_OFS, 32'h64);
      wb(1'b1, `AM_OFF1_OFS, 32'h0);
      wb(1'b1, `AM_SEL1_OFS, 32'h8);
      wb(1'b1, `AM_SEL2_OFS, 32'hb);
      @(posedge clk_i);
      pdone <= 1'b0;
      g2 <= 1'b0;
      wt();
      chk(rec1, 32'h0);
      chk(rec2, exp_code(1000, 250, -50));
      wb(1'b1, `AM_OUT1_OFS, 32'h1234);
      wb(1'b0, `AM_OUT1_OFS, 32'h0);
      chk(rd, 32'h0);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wt();
      chk(rec1, exp_code(1000, 100, 0));
      wb(1'b0, `AM_SEL2_OFS, 32'h0);
      chk(rd, 32'h0);
      end_of_test();
   end
endmodule
